/* File: rtl/radio_frame_builder.sv */
// radio sample frame builder: frame timing, byte interleave, register port
`timescale 1ns/1ps
`include "frame_map.svh"
module radio_frame_builder #(
    parameter int FRAME_CYCLES = `FB_FRAME_NS / `FB_CLK_NS
) (
    input  wire logic        mclk_i,
    input  wire logic        sys_rst_i,
    input  wire logic        second_strobe_i,
    input  wire logic [15:0] adc_data_i,
    input  wire logic        out_ready_i,
    output logic      [7:0]  out_data_o,
    output logic             out_valid_o,
    output logic             out_first_o,
    input  wire logic [7:0]  reg_addr_i,
    input  wire logic [31:0] reg_wdata_i,
    input  wire logic        reg_wr_i,
    input  wire logic        reg_rd_i,
    output logic      [31:0] reg_rdata_o,
    output logic             running_o
);
    localparam int          SUB_CYCLES = FRAME_CYCLES / `FB_SUBS_PER_FRAME;
    localparam logic [31:0] SUB_LAST   = 32'(SUB_CYCLES - 1);
    localparam logic [31:0] FRAME_LAST = 32'(FRAME_CYCLES - 1);

    sample_if sif ();

    frame_pkg::builder_state_t st_reg;
    logic        strobe_sync;
    logic        strobe_d_reg;
    logic        strobe_rise;
    logic [2:0]  phase_reg;
    logic        tick_reg;
    logic [31:0] cyc_reg;
    logic [3:0]  sub_reg;
    logic [3:0]  blk_reg;
    logic        sub_tick;
    logic        frame_start;
    logic [8:0]  off_reg;
    logic [1:0]  g3_reg;
    logic [7:0]  grp_reg;
    logic        word_hi_reg;
    logic [7:0]  lo_reg;
    logic        load;
    logic        extra;
    logic        last_byte;
    logic [7:0]  byte_next;
    logic [2:0]  rad_idx;
    logic [1:0]  tag_idx;
    logic [39:0] acc_reg;
    logic [39:0] rad_snap_reg;
    logic [23:0] tag_reg;
    logic [23:0] tag_snap_reg;
    logic [31:0] square;
    logic [2:0]  ctrl_sel_reg;
    logic [2:0]  frame_sel_reg;
    logic        overrun_reg;
    logic        overrun_set;
    logic        overrun_clr;
    logic [31:0] gap_reg;
    logic        gap_seen_reg;

    pin_sync #(
        .WIDTH (1)
    ) u_strobe_sync (
        .mclk_i    (mclk_i),
        .sys_rst_i (sys_rst_i),
        .d_i       (second_strobe_i),
        .q_o       (strobe_sync)
    );

    pin_sync #(
        .WIDTH (16)
    ) u_adc_sync (
        .mclk_i    (mclk_i),
        .sys_rst_i (sys_rst_i),
        .d_i       (adc_data_i),
        .q_o       (sif.adc)
    );

    test_pattern_gen u_pattern (
        .mclk_i    (mclk_i),
        .sys_rst_i (sys_rst_i),
        .sif       (sif.src)
    );

    // edge taken from the synchronised strobe, never the raw pin
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            strobe_d_reg <= 1'b0;
        end else begin
            strobe_d_reg <= strobe_sync;
        end
    end
    assign strobe_rise = strobe_sync && !strobe_d_reg;

    // 10 MS/s tick from 25 MHz: two ticks every five clocks
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            phase_reg <= 3'h0;
            tick_reg  <= 1'b0;
        end else if (frame_start) begin
            phase_reg <= 3'h0;  // tick grid locked to the frame
            tick_reg  <= 1'b0;
        end else if (phase_reg + `FB_TICK_STEP >= `FB_TICK_MOD) begin
            phase_reg <= phase_reg + `FB_TICK_STEP - `FB_TICK_MOD;
            tick_reg  <= 1'b1;
        end else begin
            phase_reg <= phase_reg + `FB_TICK_STEP;
            tick_reg  <= 1'b0;
        end
    end

    // a sub-frame tick every 102.4 ms; the first one is the strobe itself
    assign sub_tick = (st_reg == frame_pkg::ST_IDLE) ? strobe_rise
                      : (cyc_reg == SUB_LAST);
    assign frame_start = sub_tick && (sub_reg == 4'h0);

    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            st_reg <= frame_pkg::ST_IDLE;
        end else begin
            unique case (st_reg)
                frame_pkg::ST_IDLE: begin
                    if (strobe_rise) begin
                        st_reg <= frame_pkg::ST_EMIT;
                    end
                end
                frame_pkg::ST_GAP: begin
                    if (sub_tick) begin
                        st_reg <= frame_pkg::ST_EMIT;
                    end
                end
                frame_pkg::ST_EMIT: begin
                    if (!sub_tick && load && last_byte) begin
                        st_reg <= frame_pkg::ST_GAP;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            running_o <= 1'b0;
        end else if (strobe_rise) begin
            running_o <= 1'b1;
        end
    end

    // sub-frame counters; no stop once running
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cyc_reg <= 32'h0000_0000;
            sub_reg <= 4'h0;
            blk_reg <= 4'h0;
        end else if (sub_tick) begin
            cyc_reg <= 32'h0000_0000;
            blk_reg <= sub_reg;
            sub_reg <= (sub_reg == `FB_LAST_SUB) ? 4'h0 : sub_reg + 4'h1;
        end else if (st_reg != frame_pkg::ST_IDLE) begin
            cyc_reg <= cyc_reg + 32'h0000_0001;
        end
    end

    // selection frozen per frame so the status byte matches the samples
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            frame_sel_reg <= `FB_CTRL_RESET;
        end else if (frame_start) begin
            frame_sel_reg <= ctrl_sel_reg;
        end
    end

    assign sif.tick        = tick_reg;
    assign sif.frame_start = frame_start;
    // at a frame start the pattern source already sees the new selection
    assign sif.sel         = frame_pkg::input_sel_t'(frame_start ?
                             ctrl_sel_reg : frame_sel_reg);

    // power integration, cleared at each frame start
    assign square = 32'($signed(sif.sample) * $signed(sif.sample));
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            acc_reg      <= 40'h00_0000_0000;
            rad_snap_reg <= 40'h00_0000_0000;
        end else begin
            if (sub_tick) begin
                rad_snap_reg <= acc_reg;
            end
            // idle clear keeps pre-start samples out of the first frame
            if (frame_start || st_reg == frame_pkg::ST_IDLE) begin
                acc_reg <= 40'h00_0000_0000;
            end else if (tick_reg) begin
                acc_reg <= acc_reg + {8'h00, square};
            end
        end
    end

    // time tag: zero at start, never cleared by frames
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            tag_reg      <= 24'h00_0000;
            tag_snap_reg <= 24'h00_0000;
        end else if (sub_tick) begin
            tag_snap_reg <= tag_reg;
            tag_reg      <= tag_reg + 24'h00_0001;
        end
    end

    // byte map: block 0 opens with triplets of one side byte and an
    // I/Q word; later blocks start them after six sample bytes, so only block 0 carries marker and status
    assign load  = (st_reg == frame_pkg::ST_EMIT) && !sub_tick
                   && (!out_valid_o || out_ready_i);
    assign extra = (grp_reg < `FB_HEAD_GROUPS) && (g3_reg == 2'h0)
                   && (blk_reg == 4'h0 || grp_reg >= `FB_RAD_FIRST_GRP);
    assign last_byte = (blk_reg == `FB_LAST_SUB) ?
                       (off_reg == `FB_TAIL_LAST) : (off_reg == `FB_BLOCK_LAST);
    assign rad_idx = 3'(`FB_RAD_LAST_GRP - grp_reg);
    assign tag_idx = 2'(`FB_TAG_LAST_GRP - grp_reg);

    always_comb begin
        byte_next = 8'h00;
        if (extra) begin
            if (grp_reg == 8'h00) begin
                byte_next = `FB_ID_BYTE;
            end else if (grp_reg == `FB_STATUS_GRP) begin
                byte_next = {1'b0, frame_sel_reg, 4'h0};
            end else if (grp_reg < `FB_TAG_FIRST_GRP) begin
                byte_next = rad_snap_reg[8*rad_idx +: 8];
            end else begin
                byte_next = tag_snap_reg[8*tag_idx +: 8];
            end
        end else if (word_hi_reg) begin
            byte_next = sif.sample[15:8];
        end else begin
            byte_next = lo_reg;
        end
    end

    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            off_reg     <= 9'h000;
            g3_reg      <= 2'h0;
            grp_reg     <= 8'h00;
            word_hi_reg <= 1'b1;
            lo_reg      <= 8'h00;
        end else if (sub_tick) begin
            off_reg     <= 9'h000;
            g3_reg      <= 2'h0;
            grp_reg     <= 8'h00;
            word_hi_reg <= 1'b1;
        end else if (load) begin
            off_reg <= off_reg + 9'h001;
            if (g3_reg == 2'h2) begin
                g3_reg  <= 2'h0;
                grp_reg <= grp_reg + 8'h01;
            end else begin
                g3_reg <= g3_reg + 2'h1;
            end
            if (!extra) begin
                word_hi_reg <= !word_hi_reg;
                if (word_hi_reg) begin
                    lo_reg <= sif.sample[7:0];  // word split stays coherent
                end
            end
        end
    end

    // output stage: a byte stands until the recorder takes it
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            out_data_o  <= 8'h00;
            out_valid_o <= 1'b0;
            out_first_o <= 1'b0;
        end else if (load) begin
            out_data_o  <= byte_next;
            out_valid_o <= 1'b1;
            out_first_o <= (blk_reg == 4'h0) && (off_reg == 9'h000);
        end else if (out_ready_i) begin
            out_valid_o <= 1'b0;
        end
    end

    // a stalled recorder can make a block overrun its 102.4 ms slot
    assign overrun_set = sub_tick && (st_reg == frame_pkg::ST_EMIT);
    assign overrun_clr = reg_wr_i && (reg_addr_i == `FB_REG_STATUS)
                         && reg_wdata_i[`FB_OVERRUN_BIT];

    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            overrun_reg <= 1'b0;
        end else if (overrun_set) begin
            overrun_reg <= 1'b1;
        end else if (overrun_clr) begin
            overrun_reg <= 1'b0;
        end
    end

    // default selection routes the converter
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            ctrl_sel_reg <= `FB_CTRL_RESET;
        end else if (reg_wr_i && reg_addr_i == `FB_REG_CTRL) begin
            ctrl_sel_reg <= reg_wdata_i[2:0];
        end
    end

    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            reg_rdata_o <= 32'h0000_0000;
        end else if (reg_rd_i) begin
            unique case (reg_addr_i)
                `FB_REG_CTRL:   reg_rdata_o <= {29'h0, ctrl_sel_reg};
                `FB_REG_STATUS: reg_rdata_o <= {30'h0, overrun_reg,
                                                running_o};
                `FB_REG_TAG:    reg_rdata_o <= {8'h00, tag_reg};
                default:        reg_rdata_o <= 32'h0000_0000;
            endcase
        end else begin
            reg_rdata_o <= 32'h0000_0000;
        end
    end

    // helper: cycles between frame starts
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            gap_reg      <= 32'h0000_0000;
            gap_seen_reg <= 1'b0;
        end else if (frame_start) begin
            gap_reg      <= 32'h0000_0000;
            gap_seen_reg <= 1'b1;
        end else begin
            gap_reg <= gap_reg + 32'h0000_0001;
        end
    end

    sequence s_idle_no_strobe;
        st_reg == frame_pkg::ST_IDLE && !strobe_rise;
    endsequence

    sequence s_stalled;
        out_valid_o && !out_ready_i;
    endsequence

    sequence s_marker_load;
        load && blk_reg == 4'h0 && off_reg == 9'h000;
    endsequence

    AST_WAIT_STROBE: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        s_idle_no_strobe |=> st_reg == frame_pkg::ST_IDLE)
        else $error("frames started without a second strobe");

    AST_FRAME_PERIOD: assert property (@(posedge mclk_i)
        disable iff (sys_rst_i)
        frame_start && gap_seen_reg |-> gap_reg == FRAME_LAST)
        else $error("frame period differs from 1.024 s");

    AST_NEVER_STOPS: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        st_reg != frame_pkg::ST_IDLE |=> st_reg != frame_pkg::ST_IDLE)
        else $error("frame generation stopped");

    AST_ACC_CLEARED: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        frame_start |=> acc_reg == 40'h00_0000_0000)
        else $error("power accumulator not cleared at frame start");

    AST_TAG_STEP: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        sub_tick |=> tag_snap_reg == $past(tag_reg)
                     && tag_reg == $past(tag_reg) + 24'h00_0001)
        else $error("time tag did not step by one");

    AST_TAG_FIRST_ZERO: assert property (@(posedge mclk_i)
        disable iff (sys_rst_i)
        st_reg == frame_pkg::ST_IDLE && sub_tick |=> tag_snap_reg == 24'h0)
        else $error("first time tag is not zero");

    AST_MARKER: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        s_marker_load |=> out_data_o == `FB_ID_BYTE && out_first_o)
        else $error("frame does not open with the marker byte");

    AST_STATUS: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        load && blk_reg == 4'h0 && off_reg == 9'h003
        |=> out_data_o[7] == 1'b0 && out_data_o[3:0] == 4'h0
            && out_data_o[6:4] == frame_sel_reg)
        else $error("status byte malformed");

    AST_HOLD_BYTE: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        s_stalled |=> out_valid_o && $stable(out_data_o))
        else $error("byte dropped or changed before acceptance");

    AST_BLOCK_END: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        load && last_byte && !sub_tick |=> st_reg == frame_pkg::ST_GAP)
        else $error("block length wrong");
endmodule : radio_frame_builder

/* File: shared/frame_map.svh */
// constants of the radio sample frame builder: offsets, fields, timing
`ifndef FRAME_MAP_SVH
`define FRAME_MAP_SVH

`define FB_CLK_NS          40
`define FB_FRAME_NS        1024000000
`define FB_SAMPLE_NS       100
`define FB_IMPULSE_NS      200
`define FB_SUBS_PER_FRAME  10
`define FB_TICK_STEP       3'h2
`define FB_TICK_MOD        3'h5

`define FB_ID_BYTE         8'hB7
`define FB_SEL_LSB         4
`define FB_BLOCK_LAST      9'h1FB
`define FB_TAIL_LAST       9'h1FD
`define FB_HEAD_GROUPS     8'h0A
`define FB_STATUS_GRP      8'h01
`define FB_RAD_FIRST_GRP   8'h02
`define FB_RAD_LAST_GRP    8'h06
`define FB_TAG_FIRST_GRP   8'h07
`define FB_TAG_LAST_GRP    8'h09
`define FB_LAST_SUB        4'h9

`define FB_IMPULSE_VALUE   16'h0080
`define FB_SQ_POS          16'h0100
`define FB_SQ_NEG          16'hFF00
`define FB_PRN_POS         16'h0001
`define FB_PRN_NEG         16'hFFFF
`define FB_PRN_SEED        16'hACE1
`define FB_SQ_LO_BIT       13
`define FB_SQ_MID_BIT      8
`define FB_SQ_HI_BIT       6

`define FB_REG_CTRL        8'h00
`define FB_REG_STATUS      8'h04
`define FB_REG_TAG         8'h08
`define FB_CTRL_RESET      3'h0
`define FB_OVERRUN_BIT     1

`endif

/* File: shared/frame_pkg.sv */
// types shared by the frame builder and its test pattern source
package frame_pkg;
    typedef enum logic [2:0] {
        SEL_ADC      = 3'h0,
        SEL_IMPULSE  = 3'h1,
        SEL_SQ_LO    = 3'h2,
        SEL_SQ_MID   = 3'h3,
        SEL_PRN_UNIT = 3'h4,
        SEL_PRN_FULL = 3'h5,
        SEL_SQ_HI    = 3'h6,
        SEL_ZERO     = 3'h7
    } input_sel_t;

    typedef enum {
        ST_IDLE,
        ST_GAP,
        ST_EMIT
    } builder_state_t;
endpackage : frame_pkg

/* File: shared/sample_if.sv */
// sample path between the frame builder and the test pattern source
`timescale 1ns/1ps
interface sample_if;
    logic                   tick;
    logic                   frame_start;
    frame_pkg::input_sel_t  sel;
    logic [15:0]            adc;
    logic [15:0]            sample;

    modport src (
        input  tick,
        input  frame_start,
        input  sel,
        input  adc,
        output sample
    );
    modport sink (
        output tick,
        output frame_start,
        output sel,
        output adc,
        input  sample
    );
endinterface : sample_if

/* File: rtl/pin_sync.sv */
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module pin_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             mclk_i,
    input  wire logic             sys_rst_i,
    input  wire logic [WIDTH-1:0] d_i,
    output logic      [WIDTH-1:0] q_o
);
    logic [WIDTH-1:0] meta_reg;

    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            meta_reg <= '0;
            q_o      <= '0;
        end else begin
            meta_reg <= d_i;
            q_o      <= meta_reg;
        end
    end
endmodule : pin_sync

/* File: rtl/test_pattern_gen.sv */
// sample source: converter input or one of seven test patterns
`timescale 1ns/1ps
`include "frame_map.svh"
module test_pattern_gen (
    input  wire logic mclk_i,
    input  wire logic sys_rst_i,
    sample_if.src     sif
);
    localparam logic [13:0] IMP_N = 14'(`FB_IMPULSE_NS / `FB_SAMPLE_NS);

    logic [13:0] cnt_reg;
    logic [15:0] lfsr_reg;
    logic [15:0] sample_reg;
    logic [15:0] pat_next;
    logic [13:0] cnt_use;
    logic [15:0] lfsr_use;

    // frame start is sample zero of the new pattern, so nothing of the
    // previous frame or selection leaks into a test frame
    assign cnt_use  = sif.frame_start ? 14'h0000 : cnt_reg;
    assign lfsr_use = sif.frame_start ? `FB_PRN_SEED : lfsr_reg;

    always_comb begin
        unique case (sif.sel)
            frame_pkg::SEL_ADC:      pat_next = sif.adc;
            frame_pkg::SEL_IMPULSE:  pat_next = (cnt_use < IMP_N) ?
                                     `FB_IMPULSE_VALUE : 16'h0000;
            frame_pkg::SEL_SQ_LO:    pat_next = cnt_use[`FB_SQ_LO_BIT] ?
                                     `FB_SQ_NEG : `FB_SQ_POS;
            frame_pkg::SEL_SQ_MID:   pat_next = cnt_use[`FB_SQ_MID_BIT] ?
                                     `FB_SQ_NEG : `FB_SQ_POS;
            frame_pkg::SEL_SQ_HI:    pat_next = cnt_use[`FB_SQ_HI_BIT] ?
                                     `FB_SQ_NEG : `FB_SQ_POS;
            frame_pkg::SEL_PRN_UNIT: pat_next = lfsr_use[0] ?
                                     `FB_PRN_NEG : `FB_PRN_POS;
            frame_pkg::SEL_PRN_FULL: pat_next = lfsr_use;
            frame_pkg::SEL_ZERO:     pat_next = 16'h0000;
        endcase
    end

    // patterns run at the 10 MS/s tick, replacing converter data
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cnt_reg    <= 14'h0000;
            lfsr_reg   <= `FB_PRN_SEED;
            sample_reg <= 16'h0000;
        end else if (sif.frame_start || sif.tick) begin
            cnt_reg    <= cnt_use + 14'h0001;
            lfsr_reg   <= {lfsr_use[14:0], lfsr_use[15] ^ lfsr_use[13]
                          ^ lfsr_use[12] ^ lfsr_use[10]};
            sample_reg <= pat_next;
        end
    end

    assign sif.sample = sample_reg;

    AST_ZERO_PATTERN: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        (sif.tick || sif.frame_start) && sif.sel == frame_pkg::SEL_ZERO
        |=> sample_reg == 16'h0000)
        else $error("zero pattern produced a non-zero sample");

    AST_IMPULSE_FIRST: assert property (@(posedge mclk_i)
        disable iff (sys_rst_i)
        sif.frame_start && sif.sel == frame_pkg::SEL_IMPULSE
        |=> sample_reg == `FB_IMPULSE_VALUE)
        else $error("impulse missing at frame start");
endmodule : test_pattern_gen

/* File: testbench/recorder_model.sv */
// recorder side model: accepts frame bytes, optionally stalling
`timescale 1ns/1ps
module recorder_model (
    input  wire logic mclk_i,
    input  wire logic sys_rst_i,
    input  wire logic stall_i,
    output logic      out_ready_o
);
    // stalling every other cycle keeps the hold path exercised
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) out_ready_o <= 1'b0;
        else out_ready_o <= stall_i ? ~out_ready_o : 1'b1;
    end
endmodule : recorder_model

/* File: testbench/radio_sample_frame_builder_bench.sv */
// self-checking bench of the frame builder with a recorder model
`timescale 1ns/1ps
module radio_sample_frame_builder_bench;
    localparam int FC = 20000;
    logic mclk_i = 0, sys_rst_i = 1, strobe = 0, rdy, valid, first;
    logic wr = 0, rd = 0, running, stall = 1;
    logic [15:0] adc = 16'h0000;
    logic [7:0] data, addr = 8'h00, pd;
    logic [31:0] wdata = 32'h0, rdata;
    logic [7:0] fr[0:6000], dn[0:6000];
    int cnt = 0, dlen = 0, ndone = 0, n_errors = 0, checks = 0;
    logic pv = 0, pr = 0;
    int aph = 0;
    always #20 mclk_i = ~mclk_i;
    // converter model: a new sample on 2 of every 5 clocks, 10 MS/s
    always @(posedge mclk_i) begin
        aph <= (aph + 2) % 5;
        if (aph >= 3) adc <= adc + 16'h0101;
    end
    radio_frame_builder #(.FRAME_CYCLES(FC)) i_dut (.mclk_i(mclk_i),
        .sys_rst_i(sys_rst_i), .second_strobe_i(strobe),
        .adc_data_i(adc), .out_ready_i(rdy), .out_data_o(data),
        .out_valid_o(valid), .out_first_o(first), .reg_addr_i(addr),
        .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
        .reg_rdata_o(rdata), .running_o(running));
    recorder_model i_rec (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
        .stall_i(stall), .out_ready_o(rdy));
    task automatic check(string n, logic [31:0] e, logic [31:0] g);
        checks++;
        if (e !== g) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask : check
    // hold while stalled, and frame capture on each accepted byte
    always @(posedge mclk_i) begin
        if (pv && !pr && valid === 1'b1) check("held byte", pd, data);
        pv = valid; pr = rdy; pd = data;
        if (valid === 1'b1 && rdy === 1'b1) begin
            if (first === 1'b1 && cnt > 0) begin
                for (int i = 0; i < cnt; i++) dn[i] = fr[i];
                dlen = cnt; ndone++; cnt = 0;
            end
            fr[cnt] = data; cnt++;
        end
    end
    task automatic reg_write(logic [7:0] a, logic [31:0] d);
        @(posedge mclk_i); wr <= 1'b1; addr <= a; wdata <= d;
        @(posedge mclk_i); wr <= 1'b0;
    endtask : reg_write
    task automatic reg_read(string n, logic [7:0] a, logic [31:0] e);
        @(posedge mclk_i); rd <= 1'b1; addr <= a;
        @(posedge mclk_i); rd <= 1'b0;
        #1 check(n, e, rdata);
    endtask : reg_read
    function automatic bit is_side(int i);
        int k, o;
        k = (i / 508 > 9) ? 9 : i / 508;
        o = i - 508 * k;
        return o < 30 && o % 3 == 0 && !(k > 0 && o < 6);
    endfunction : is_side
    task automatic test_idle();
        reg_read("ctrl reset", 8'h00, 32'h0);
        reg_write(8'h00, 32'h7);
        reg_read("ctrl", 8'h00, 32'h7);
        reg_read("unmapped", 8'h40, 32'h0);
        repeat (100) @(posedge mclk_i);
        check("valid before strobe", 1'b0, valid);
        check("running before strobe", 1'b0, running);
        @(posedge mclk_i); strobe <= 1'b1;
        repeat (6) @(posedge mclk_i); strobe <= 1'b0;
        check("running after strobe", 1'b1, running);
        reg_write(8'h00, 32'h4);
        $display("test idle done");
    endtask : test_idle
    task automatic check_frame(int f, logic [2:0] sel);
        logic [7:0] s[$];
        int b, t;
        logic [15:0] w;
        for (int n = 0; n < FC + 4000 && ndone <= f; n++) @(posedge mclk_i);
        check("frame length", 5082, dlen);
        check("marker", 8'hB7, dn[0]);
        check("status", {1'b0, sel, 4'h0}, dn[3]);
        for (int k = 0; k < 10; k++) begin
            b = 508 * k; t = 10 * f + k;
            check("tag", t, {dn[b+21], dn[b+24], dn[b+27]});
            if (f == 0 || (f == 1 && k == 0)) begin
                for (int j = 0; j < 5; j++)
                    check("power", 8'h00, dn[b+6+3*j]);
            end
        end
        for (int i = 0; i < dlen; i++) if (!is_side(i)) s.push_back(dn[i]);
        check("sample bytes", 5000, s.size());
        // the second word may fall on either side of the impulse end
        for (int i = 0; i + 1 < s.size(); i += 2) begin
            w = {s[i], s[i+1]};
            if (sel == 3'h7) check("zero sample", 16'h0, w);
            else if (sel == 3'h1 && i != 2)
                check("impulse", (i == 0) ? 16'h0080 : 16'h0, w);
            else if (sel == 3'h4 && w !== 16'hFFFF)
                check("unit noise", 16'h0001, w);
        end
        $display("test frame %0d done", f);
    endtask : check_frame
    task automatic test_status();
        reg_read("status", 8'h04, 32'h1);
        reg_write(8'h04, 32'h2);
        reg_read("status after clear", 8'h04, 32'h1);
        reg_read("tag", 8'h08, 32'h1F);
        $display("test status done");
    endtask : test_status
    task automatic end_of_test();
        $display("checks %0d errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : end_of_test
    initial begin
        #(80000 * 40);
        n_errors++;
        end_of_test();
    end
    initial begin
        repeat (16) @(posedge mclk_i);
        sys_rst_i <= 1'b0;
        test_idle();
        check_frame(0, 3'h7);
        reg_write(8'h00, 32'h1);
        check_frame(1, 3'h4);
        check_frame(2, 3'h1);
        test_status();
        end_of_test();
    end
endmodule : radio_sample_frame_builder_bench
